//--- verilog/swt_pkg.sv
// Package of constants shared by the wake timer block
package swt_pkg;
   localparam int SWT_COUNT_W = 41;
   localparam int SWT_NUM_TIMERS = 2;
   // Value reloaded when a running count passes zero
   localparam logic [40:0] SWT_ROLLOVER = 41'h01FFFFFFFFF;
   localparam logic [40:0] SWT_ZERO = 41'h00000000000;
   localparam logic [40:0] SWT_ONE = 41'h00000000001;
   localparam int SWT_LP_CLK_HZ = 32000;
   localparam int SWT_REF_CLK_HZ = 125000000;
   // Reference cycles per low-power tick, rounded down
   localparam int SWT_TICK_CYCLES = SWT_REF_CLK_HZ / SWT_LP_CLK_HZ;
   localparam int SWT_FIRST_BIT = 0;
   localparam int SWT_SECOND_BIT = 1;
   typedef enum logic [0:0] {
      SWT_IDLE = 1'b0,
      SWT_RUN  = 1'b1
   } swt_state_e;
endpackage

//--- verilog/swt_channel.sv
// One wake countdown channel: load, stop, decrement, rollover
`timescale 1ns/1ps
module swt_channel
   import swt_pkg::*;
#(
   parameter int COUNT_W = SWT_COUNT_W
) (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic tick_i,
   input wire logic start_i,
   input wire logic stop_i,
   input wire logic irq_en_write_i,
   input wire logic irq_en_value_i,
   input wire logic [COUNT_W-1:0] load_count_i,
   output logic [COUNT_W-1:0] count_o,
   output logic active_o,
   output logic expire_o,
   output logic irq_en_stored_o,
   output logic irq_en_armed_o
);
   swt_state_e state_reg;
   logic [COUNT_W-1:0] count_reg;
   logic expire_reg;
   logic stored_reg;
   logic armed_reg;
   logic halt;

   // Stop command or an enable write both halt the countdown
   assign halt = stop_i | irq_en_write_i;

   // Run state; stays running through rollover
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= SWT_IDLE;
      end else if (start_i) begin
         state_reg <= SWT_RUN;
      end else if (halt) begin
         state_reg <= SWT_IDLE;
      end
   end

   // Counter: load, decrement per tick, reload SWT_ROLLOVER (low 37 bits set) after zero
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         count_reg <= SWT_ZERO;
      end else if (start_i) begin
         count_reg <= load_count_i;
      end else if (state_reg == SWT_RUN && !halt && tick_i) begin
         if (count_reg == SWT_ZERO) begin
            count_reg <= SWT_ROLLOVER;
         end else begin
            count_reg <= count_reg - SWT_ONE;
         end
      end
   end

   // One-cycle expiry pulse when a running count passes zero
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         expire_reg <= 1'b0;
      end else begin
         expire_reg <= state_reg == SWT_RUN && !halt && !start_i &&
                       tick_i && count_reg == SWT_ZERO;
      end
   end

   // Stored enable only changes on a write; stop leaves it alone
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         stored_reg <= 1'b0;
      end else if (irq_en_write_i) begin
         stored_reg <= irq_en_value_i;
      end
   end

   // Armed copy latched at start so later writes do not alter the armed enable
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         armed_reg <= 1'b0;
      end else if (start_i) begin
         armed_reg <= stored_reg;
      end
   end

   assign count_o = count_reg;
   assign active_o = state_reg == SWT_RUN;
   assign expire_o = expire_reg;
   assign irq_en_stored_o = stored_reg;
   assign irq_en_armed_o = armed_reg;
endmodule

//--- verilog/swt_top.sv
// Two wake countdown timers with status maps and wake output
`timescale 1ns/1ps
module swt_top
   import swt_pkg::*;
#(
   parameter int COUNT_W = SWT_COUNT_W,
   parameter int TICK_CYCLES = SWT_TICK_CYCLES
) (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic lp_clk_i,
   input wire logic lp_src_sel_i,
   input wire logic sleep_i,
   input wire logic timer_select_i,
   input wire logic start_i,
   input wire logic stop_i,
   input wire logic irq_en_write_i,
   input wire logic expiry_irq_enable_i,
   input wire logic [COUNT_W-1:0] load_count_i,
   input wire logic fired_read_i,
   output logic [COUNT_W-1:0] count_o,
   output logic [SWT_NUM_TIMERS-1:0] active_o,
   output logic [SWT_NUM_TIMERS-1:0] fired_o,
   output logic [SWT_NUM_TIMERS-1:0] expiry_irq_o,
   output logic wake_o,
   output logic lp_src_sel_o
);
   // Divider width and end points for the fallback tick; the default
   // period rounds down, so the divider runs a little fast
   localparam int TICK_W = $clog2(TICK_CYCLES + 1);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
   localparam logic [TICK_W-1:0] TICK_ZERO = '0;
   localparam logic [TICK_W-1:0] TICK_STEP = TICK_W'(1);

   // Tick path: pin synchroniser, edge history and fallback divider
   logic lp_meta_reg;
   logic lp_sync_reg;
   logic lp_prev_reg;
   logic lp_seen_reg;
   logic lp_rise;
   logic [TICK_W-1:0] div_reg;
   logic div_tick;
   logic tick;
   logic src_reg;

   // Per-timer command strobes, status and results
   logic [SWT_NUM_TIMERS-1:0] sel_vec;
   logic [SWT_NUM_TIMERS-1:0] fired_reg;
   logic [SWT_NUM_TIMERS-1:0] expire;
   logic [SWT_NUM_TIMERS-1:0] armed;
   logic [SWT_NUM_TIMERS-1:0] armed_expire;
   logic [SWT_NUM_TIMERS-1:0] active;
   logic [COUNT_W-1:0] cnt [SWT_NUM_TIMERS];
   logic [COUNT_W-1:0] count_reg;
   logic [SWT_NUM_TIMERS-1:0] irq_reg;
   logic wake_reg;

   // Address decode of the one-bit timer identity; a function, so a wider
   // identity would change here and also in the timer_select_i port width and SWT_NUM_TIMERS
   function automatic logic [SWT_NUM_TIMERS-1:0] sel_map(input logic s);
      sel_map = s ? (2'h1 << SWT_SECOND_BIT) : (2'h1 << SWT_FIRST_BIT);
   endfunction

   // One-hot strobe mask for the addressed timer
   assign sel_vec = sel_map(timer_select_i);

   // Low-power clock pin crosses two flops before use; only the second
   // feeds logic, so a metastable first sample never reaches a count
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lp_meta_reg <= 1'b0;
         lp_sync_reg <= 1'b0;
      end else begin
         lp_meta_reg <= lp_clk_i;
         lp_sync_reg <= lp_meta_reg;
      end
   end

   // Edge history of the synced pin level; reset low like the sync flops
   // so a pin held low gives no false edge after reset
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lp_prev_reg <= 1'b0;
      end else begin
         lp_prev_reg <= lp_sync_reg;
      end
   end

   // Rising edge of the synced pin, two reference cycles after the pin
   assign lp_rise = lp_sync_reg & ~lp_prev_reg;

   // Seen flag: once the pin toggles, edges drive the tick; a board with
   // the pin tied low keeps running from the divider
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lp_seen_reg <= 1'b0;
      end else if (lp_rise) begin
         lp_seen_reg <= 1'b1;
      end
   end

   // Fallback divider when no pin clock runs; pin edges take priority
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_reg <= TICK_ZERO;
      end else if (div_tick) begin
         div_reg <= TICK_ZERO;
      end else begin
         div_reg <= div_reg + TICK_STEP;
      end
   end

   // Divider wrap, one nominal low-power period of reference cycles
   assign div_tick = div_reg == TICK_LAST;

   // Tick source: pin edges once the pin has toggled, else the divider.
   // The switch is one-way until reset: a pin that stalls after its first
   // edge stops both timers rather than falling back to the divider.
   assign tick = lp_seen_reg ? lp_rise : div_tick;

   // Source selection held here; only reset clears it, not sleep.
   // Captured only while awake, so the select input may float while
   // the device sleeps without moving the clock source
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         src_reg <= 1'b0;
      end else if (!sleep_i) begin
         src_reg <= lp_src_sel_i;
      end
   end

   // Two independent channels on one shared tick; strobes reach only
   // the addressed channel, the enable value goes to both
   for (genvar g = 0; g < SWT_NUM_TIMERS; g++) begin : g_ch
      swt_channel #(
         .COUNT_W(COUNT_W)
      ) u_ch (
         .ref_clk_i(ref_clk_i),
         .arst_n_i(arst_n_i),
         .tick_i(tick),
         .start_i(start_i & sel_vec[g]),
         .stop_i(stop_i & sel_vec[g]),
         .irq_en_write_i(irq_en_write_i & sel_vec[g]),
         .irq_en_value_i(expiry_irq_enable_i),
         .load_count_i(load_count_i),
         .count_o(cnt[g]),
         .active_o(active[g]),
         .expire_o(expire[g]),
         .irq_en_stored_o(),
         .irq_en_armed_o(armed[g])
      );
   end

   // Fired bits: a read clears them, a same-cycle expiry wins so that
   // no firing is lost between a read and the next
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fired_reg <= '0;
      end else if (fired_read_i) begin
         fired_reg <= expire;
      end else begin
         fired_reg <= fired_reg | expire;
      end
   end

   // Live count of the selected timer, read without side effects; the
   // flop adds one cycle of lag, far below one low-power period
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         count_reg <= SWT_ZERO;
      end else begin
         count_reg <= cnt[timer_select_i];
      end
   end

   // Expiries that were armed at start; only these interrupt or wake
   assign armed_expire = expire & armed;

   // Interrupt pulses use the enable armed at start, one cycle each;
   // a write after start halts that timer; its value is armed only at the next start
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_reg <= '0;
      end else begin
         irq_reg <= armed_expire;
      end
   end

   // Wake pulse only for an armed expiry while asleep; an awake
   // expiry still raises its interrupt but never wakes
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wake_reg <= 1'b0;
      end else begin
         wake_reg <= sleep_i & |armed_expire;
      end
   end

   // Outputs straight from flops or run state
   assign count_o = count_reg;
   assign active_o = active;
   assign fired_o = fired_reg;
   assign expiry_irq_o = irq_reg;
   assign wake_o = wake_reg;
   assign lp_src_sel_o = src_reg;
endmodule

//--- tb/swt_monitor.sv
// Port-level checks for the wake timer pair
`timescale 1ns/1ps
module swt_monitor
   import swt_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic sleep_i,
   input wire logic timer_select_i,
   input wire logic start_i,
   input wire logic stop_i,
   input wire logic irq_en_write_i,
   input wire logic fired_read_i,
   input wire logic [1:0] active_o,
   input wire logic [1:0] fired_o,
   input wire logic [1:0] expiry_irq_o,
   input wire logic wake_o,
   input wire logic lp_src_sel_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);
   // Stop of the first timer, then idle with no interrupt
   sequence stop0_s;
      stop_i && !start_i && !timer_select_i;
   endsequence
   sequence quiet0_s;
      !active_o[0] ##2 !expiry_irq_o[0] [*3];
   endsequence
   start_act_a: assert property (start_i && !timer_select_i
      |=> active_o[0]) else $error("start missed");
   stop_quiet_a: assert property (stop0_s |=> quiet0_s)
      else $error("stop not quiet");
   en_stop_a: assert property (irq_en_write_i && !start_i
      |=> !active_o[$past(timer_select_i)]) else $error("write kept run");
   keep_act_a: assert property (active_o[0]
      && !((stop_i || irq_en_write_i) && !timer_select_i) |=> active_o[0])
      else $error("active dropped");
   irq_fire_a: assert property (expiry_irq_o[0] |-> fired_o[0])
      else $error("irq without fired");
   irq_pulse_a: assert property (expiry_irq_o != 2'h0
      |=> expiry_irq_o == 2'h0) else $error("irq too long");
   wake_src_a: assert property (wake_o |-> expiry_irq_o != 2'h0)
      else $error("wake without irq");
   fired_hold_a: assert property (fired_o[1] && !fired_read_i
      |=> fired_o[1]) else $error("fired lost");
   fired_clr_a: assert property ($fell(fired_o[0])
      |-> $past(fired_read_i)) else $error("fired cleared unread");
   src_hold_a: assert property (sleep_i |=> $stable(lp_src_sel_o))
      else $error("source changed asleep");
endmodule

//--- tb/testbench.sv
// Self-checking bench for the wake timer pair
`timescale 1ns/1ps
module testbench;
   import swt_pkg::*;
   logic clk, rst_n, slp, sel, st, sp, we, en, rd, src, src_o, wk;
   logic gi, gw, lpc;
   logic [40:0] ld, cnt, held;
   logic [1:0] act, fir, irq;
   int err_count = 0;
   int checks_done = 0;
   int cyc = 0;
   // Short tick divider keeps the run brief; pin clock runs only last
   swt_top #(.TICK_CYCLES(4)) swt_top_i (.ref_clk_i(clk),
      .arst_n_i(rst_n), .lp_clk_i(lpc), .lp_src_sel_i(src),
      .sleep_i(slp), .timer_select_i(sel), .start_i(st), .stop_i(sp),
      .irq_en_write_i(we), .expiry_irq_enable_i(en), .load_count_i(ld),
      .fired_read_i(rd), .count_o(cnt), .active_o(act), .fired_o(fir),
      .expiry_irq_o(irq), .wake_o(wk), .lp_src_sel_o(src_o));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task stop_test;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Hang guard well above the expected run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         err_count++;
         stop_test;
      end
   end
   task chk(input string nm, input logic [40:0] x, g);
      checks_done++;
      if (g !== x) begin
         err_count++;
         $display("wrong value %s exp %h got %h", nm, x, g);
      end
   endtask
   // One command cycle; returns mid-cycle after the taking edge
   task cmd(input logic s, a, b, c, e, input logic [40:0] l);
      @(posedge clk);
      sel <= s; st <= a; sp <= b; we <= c; en <= e; ld <= l;
      @(posedge clk);
      st <= 1'b0; sp <= 1'b0; we <= 1'b0;
      @(negedge clk);
   endtask
   task watch(input int n);
      gi = 1'b0;
      gw = 1'b0;
      repeat (n) begin
         @(negedge clk);
         gi |= irq[sel];
         gw |= wk;
      end
   endtask
   task rdf;
      @(posedge clk);
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
   endtask
   task t_fire_wake;
      chk("src", 1, src_o);
      @(posedge clk);
      slp <= 1'b1; src <= 1'b0;
      cmd(0, 0, 0, 1, 1, 0);
      cmd(0, 1, 0, 0, 0, 5);
      chk("act", 2'h1, act);
      @(negedge clk);
      chk("count", 5, cnt);
      watch(30);
      chk("irq", 1, gi);
      chk("wake", 1, gw);
      chk("fired", 2'h1, fir);
      chk("roll", SWT_ROLLOVER[40:4], cnt[40:4]);
      chk("src", 1, src_o);
      rdf;
      chk("fired", 0, fir);
   endtask
   task t_quiet_second;
      cmd(1, 0, 0, 1, 0, 0);
      cmd(1, 1, 0, 0, 0, 2);
      chk("act", 2'h3, act);
      watch(24);
      chk("irq", 0, gi);
      chk("wake", 0, gw);
      chk("fired", 2'h2, fir);
      rdf;
   endtask
   // Stop freezes the count and keeps the stored enable
   task t_stop_keep;
      @(posedge clk);
      slp <= 1'b0;
      cmd(0, 0, 1, 0, 0, 0);
      chk("act", 2'h2, act);
      chk("src", 0, src_o);
      repeat (2) @(negedge clk);
      held = cnt;
      repeat (12) @(negedge clk);
      chk("frozen", held, cnt);
      cmd(0, 1, 0, 0, 0, 3);
      watch(24);
      chk("irq", 1, gi);
      chk("wake", 0, gw);
      rdf;
      cmd(0, 0, 0, 1, 0, 0);
      chk("act", 2'h2, act);
      cmd(0, 1, 0, 0, 0, 3);
      watch(24);
      chk("irq", 0, gi);
      chk("fired", 2'h1, fir);
   endtask
   // Pin clock of eight reference cycles a period
   task lp_cycles(input int n);
      repeat (2 * n) begin
         repeat (4) @(posedge clk);
         lpc <= ~lpc;
      end
   endtask
   // Once the pin has toggled, each rising edge is one tick
   task t_pin_clock;
      lp_cycles(1);
      cmd(0, 1, 0, 0, 0, 41'h00000000010);
      lp_cycles(5);
      repeat (3) @(negedge clk);
      chk("pin", 41'h0000000000B, cnt);
   endtask
   initial begin
      rst_n = 1'b0; slp = 1'b0; sel = 1'b0; st = 1'b0; sp = 1'b0;
      we = 1'b0; en = 1'b0; rd = 1'b0; src = 1'b1; ld = '0; lpc = 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(negedge clk);
      t_fire_wake;
      t_quiet_second;
      t_stop_keep;
      t_pin_clock;
      stop_test;
   end
endmodule
bind swt_top swt_monitor swt_monitor_i (.*);
